// *** inc/decoder_pkg.sv ***
// Shared constants, codes and carrier types for the instruction decoder
package decoder_pkg;
    localparam int INSTR_W = 14;
    localparam int DATA_W  = 8;
    localparam int PC_W    = 15;
    localparam int PTR_W   = 16;
    localparam int APB_AW  = 8;

    // Full-word opcodes
    localparam logic [13:0] OPC_BRANCH_REL_WREG = 14'h000B;
    localparam logic [13:0] OPC_CALL_REL_WREG   = 14'h000A;
    localparam logic [13:0] OPC_SLEEP  = 14'h0063;
    localparam logic [13:0] OPC_OPTION = 14'h0062;
    // Opcode prefixes, compared against the top bits of the word; DIR_SEL_FIRST is compared against the low three bits
    localparam logic [5:0]  OPC_RETURN_LIT_HI = 6'h34;
    localparam logic [5:0]  OPC_DEC_SKIP_HI   = 6'h0B;
    localparam logic [10:0] OPC_PIN_DIR_HI    = 11'h00C;
    localparam logic [10:0] OPC_IND_READ_HI   = 11'h002;
    localparam logic [10:0] OPC_IND_WRITE_HI  = 11'h003;
    localparam logic [6:0]  OPC_ADD_PTR_HI    = 7'h62;
    localparam logic [6:0]  OPC_IDXRD_HI  = 7'h7E;
    localparam logic [6:0]  OPC_IDXWR_HI  = 7'h7F;
    localparam logic [2:0]  OPC_JUMP_ABS_HI = 3'h5;
    localparam logic [2:0]  DIR_SEL_FIRST = 3'h5;

    // Pre/post modify field codes
    localparam logic [1:0] MM_PRE_INC  = 2'h0;
    localparam logic [1:0] MM_PRE_DEC  = 2'h1;
    localparam logic [1:0] MM_POST_INC = 2'h2;
    localparam logic [1:0] MM_POST_DEC = 2'h3;

    // Register map (byte addresses)
    localparam logic [APB_AW-1:0] REG_WREG   = 8'h00;
    localparam logic [APB_AW-1:0] REG_PC_LATCH = 8'h04;
    localparam logic [APB_AW-1:0] REG_PTR0   = 8'h08;
    localparam logic [APB_AW-1:0] REG_PTR1   = 8'h0C;
    localparam logic [APB_AW-1:0] REG_PC     = 8'h10;
    localparam logic [APB_AW-1:0] REG_STATUS = 8'h14;
    localparam logic [APB_AW-1:0] REG_OPTION = 8'h18;
    localparam logic [APB_AW-1:0] REG_PINDIR = 8'h1C;

    // Status register bit positions
    localparam int ST_ZERO    = 0;
    localparam int ST_TIMEOUT = 1;
    localparam int ST_PWRDN   = 2;
    localparam int ST_STANDBY = 3;

    // Reset values
    localparam logic [DATA_W-1:0] OPTION_RST = 8'hFF;
    localparam logic [DATA_W-1:0] PINDIR_RST = 8'hFF;
    localparam logic [PTR_W-1:0]  PTR_RST    = 16'h0000;
    localparam logic [PC_W-1:0]   PC_RST     = 15'h0000;

    typedef enum logic [3:0] {
        SQ_EXEC  = 4'h1,
        SQ_FLUSH = 4'h2,
        SQ_EXTRA = 4'h4,
        SQ_SLEEP = 4'h8
    } seq_state_e;

    typedef struct packed {
        logic branchRel;
        logic callRel;
        logic retLit;
        logic jumpAbs;
        logic sleep;
        logic option;
        logic pinDir;
        logic addPtr;
        logic readMod;
        logic writeMod;
        logic readIdx;
        logic writeIdx;
        logic decSkip;
    } decode_s;

    typedef struct packed {
        logic [PTR_W-1:0]  addr;
        logic [DATA_W-1:0] wdata;
        logic              write;
    } mem_req_s;
endpackage

// *** logic/instr_decoder.sv ***
// Instruction decoder and sequencer with APB register access
`timescale 1ns/1ps

module instr_decoder
    import decoder_pkg::*;
#(
    parameter int STACK_DEPTH = 16
) (
    input  wire logic                core_clk,
    input  wire logic                sys_rst,
    input  wire logic [INSTR_W-1:0]  instr,
    input  wire logic                instrValid,
    output logic                     instrReady,
    output logic [PC_W-1:0]          pc,
    output mem_req_s                 memReq,
    input  wire logic [DATA_W-1:0]   memRdata,
    input  wire logic                wakePin,
    output logic                     standby,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [APB_AW-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr
);
    localparam int SPW = $clog2(STACK_DEPTH);

    if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_depth
        $error("STACK_DEPTH must be a power of two of at least 2");
    end

    function automatic decode_s decode(input logic [INSTR_W-1:0] w);
        decode_s d;
        d          = '0;
        d.branchRel = (w == OPC_BRANCH_REL_WREG);
        d.callRel   = (w == OPC_CALL_REL_WREG);
        d.sleep    = (w == OPC_SLEEP);
        d.option   = (w == OPC_OPTION);
        d.retLit   = (w[13:8] == OPC_RETURN_LIT_HI);
        d.decSkip  = (w[13:8] == OPC_DEC_SKIP_HI);
        d.jumpAbs  = (w[13:11] == OPC_JUMP_ABS_HI);
        d.pinDir   = (w[13:3] == OPC_PIN_DIR_HI) && (w[2:0] >= DIR_SEL_FIRST);
        d.readMod  = (w[13:3] == OPC_IND_READ_HI);
        d.writeMod = (w[13:3] == OPC_IND_WRITE_HI);
        d.addPtr   = (w[13:7] == OPC_ADD_PTR_HI);
        d.readIdx  = (w[13:7] == OPC_IDXRD_HI);
        d.writeIdx = (w[13:7] == OPC_IDXWR_HI);
        return d;
    endfunction

    seq_state_e              state;
    seq_state_e              next_state;
    logic [DATA_W-1:0]       wreg;
    logic [DATA_W-1:0]       pcHighLatch;
    logic [PTR_W-1:0]        ptr [2];
    logic [DATA_W-1:0]       optionReg;
    logic [DATA_W-1:0]       pinDirReg [3];
    logic                    zeroFlag;
    logic                    timeoutFlag;
    logic                    powerdownFlag;
    logic [PC_W-1:0]         retStack [STACK_DEPTH];
    logic [SPW-1:0]          sp;
    logic [2:0]              wakeSync;
    logic [PC_W-1:0]         next_pc;

    // Decode and operand fields
    decode_s                 dec;
    wire logic               exec      = (state == SQ_EXEC) && instrValid;
    wire logic               ptrSel    = dec.readMod || dec.writeMod ? instr[2] : instr[6];
    wire logic [1:0]         mm        = instr[1:0];
    wire logic [PTR_W-1:0]   ptrCur    = ptr[ptrSel];
    wire logic [PTR_W-1:0]   kSext     = {{(PTR_W - 6){instr[5]}}, instr[5:0]};
    wire logic [PTR_W-1:0]   ptrIdx    = ptrCur + kSext;
    wire logic [PTR_W-1:0]   ptrMod    = (mm == MM_PRE_DEC || mm == MM_POST_DEC) ? ptrCur - 16'h0001
                                                                                 : ptrCur + 16'h0001;
    wire logic               preMod    = (mm == MM_PRE_INC) || (mm == MM_PRE_DEC);
    wire logic               modAccess = dec.readMod || dec.writeMod;
    wire logic               idxAccess = dec.readIdx || dec.writeIdx;
    wire logic [PTR_W-1:0]   indAddr   = idxAccess ? ptrIdx : (preMod ? ptrMod : ptrCur);
    wire logic [DATA_W-1:0]  decResult = memRdata - 8'h01;
    wire logic               destFile  = instr[7];
    wire logic               skip      = dec.decSkip && (decResult == 8'h00);
    wire logic               extra     = (modAccess || idxAccess) && indAddr[PTR_W-1];
    wire logic               pcChange  = dec.branchRel || dec.callRel || dec.retLit || dec.jumpAbs;
    wire logic [DATA_W-1:0]  litByte   = instr[7:0];
    wire logic [PC_W-1:0]    pcInc     = pc + 15'h0001;
    wire logic [PC_W-1:0]    stackTop  = retStack[sp - 1'b1];
    wire logic [PC_W-1:0]    jumpTarget = {pcHighLatch[6:3], instr[10:0]};
    wire logic               wakeSeen  = wakeSync[1] && wakeSync[2];
    wire logic [1:0]         dirIdx    = 2'(instr[2:0] - DIR_SEL_FIRST);

    assign dec = decode(instr);

    // APB decode
    wire logic               apbSetup  = psel && !penable;
    wire logic               apbWr     = psel && penable && pwrite;
    wire logic               aligned   = (paddr[1:0] == 2'h0);
    wire logic               wrW       = apbWr && paddr == REG_WREG;
    wire logic               wrLatch   = apbWr && paddr == REG_PC_LATCH;
    wire logic [1:0]         wrPtr     = {apbWr && paddr == REG_PTR1, apbWr && paddr == REG_PTR0};
    wire logic               mapped    = aligned && paddr <= REG_PINDIR;
    wire logic [3:0]         statusVal = {standby, powerdownFlag, timeoutFlag, zeroFlag};
    logic [31:0]             readMux;

    always_comb begin
        case (paddr)
            REG_WREG:   readMux = {24'h000000, wreg};
            REG_PC_LATCH: readMux = {24'h000000, pcHighLatch};
            REG_PTR0:   readMux = {16'h0000, ptr[0]};
            REG_PTR1:   readMux = {16'h0000, ptr[1]};
            REG_PC:     readMux = {17'h00000, pc};
            REG_STATUS: readMux = {28'h0000000, statusVal};
            REG_OPTION: readMux = {24'h000000, optionReg};
            REG_PINDIR: readMux = {8'h00, pinDirReg[2], pinDirReg[1], pinDirReg[0]};
            default:    readMux = 32'h00000000;
        endcase
    end

    // Read data and error are latched in the setup cycle so they hold through the access
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (apbSetup) begin
            prdata  <= pwrite ? 32'h00000000 : readMux;
            pslverr <= !mapped;
        end
    end

    assign pready = psel && penable;

    // Sequencer
    assign instrReady = (state == SQ_EXEC) || (state == SQ_FLUSH);
    assign standby    = (state == SQ_SLEEP);

    always_comb begin
        next_state = state;
        case (state)
            SQ_EXEC: begin
                if (exec && dec.sleep) begin
                    next_state = SQ_SLEEP;
                end else if (exec && (pcChange || skip)) begin
                    next_state = SQ_FLUSH;
                end else if (exec && extra) begin
                    next_state = SQ_EXTRA;
                end
            end
            SQ_FLUSH: next_state = instrValid ? SQ_EXEC : SQ_FLUSH;
            SQ_EXTRA: next_state = SQ_EXEC;
            SQ_SLEEP: next_state = wakeSeen ? SQ_EXEC : SQ_SLEEP;
            default:  next_state = SQ_EXEC;
        endcase
    end

    always_comb begin
        next_pc = pcInc;
        if (dec.branchRel) begin
            next_pc = pcInc + {7'h00, wreg};
        end else if (dec.callRel) begin
            next_pc = {pcHighLatch[6:0], wreg};
        end else if (dec.retLit) begin
            next_pc = stackTop;
        end else if (dec.jumpAbs) begin
            next_pc = jumpTarget;
        end else if (skip) begin
            // The flush cycle drops the skipped word, so the PC must step past it here
            next_pc = pcInc + 15'h0001;
        end
    end

    // The flush cycle consumes the fetched word without executing it
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= SQ_EXEC;
            pc    <= PC_RST;
        end else begin
            state <= next_state;
            if (exec) begin
                pc <= next_pc;
            end
        end
    end

    // Return stack wraps silently on overflow, like a circular hardware stack
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sp <= '0;
        end else if (exec && dec.callRel) begin
            retStack[sp] <= pcInc;
            sp           <= sp + 1'b1;
        end else if (exec && dec.retLit) begin
            sp <= sp - 1'b1;
        end
    end

    // Memory port: file register for decrement-skip, pointer target otherwise
    assign memReq.addr  = dec.decSkip ? {9'h000, instr[6:0]} : indAddr;
    assign memReq.wdata = dec.decSkip ? decResult : wreg;
    assign memReq.write = exec && (dec.writeMod || dec.writeIdx
                                   || (dec.decSkip && destFile));

    // Software writes to W win over the core in the same cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wreg <= 8'h00;
        end else if (wrW) begin
            wreg <= pwdata[7:0];
        end else if (exec && dec.retLit) begin
            wreg <= litByte;
        end else if (exec && (dec.readMod || dec.readIdx)) begin
            wreg <= memRdata;
        end else if (exec && dec.decSkip && !destFile) begin
            wreg <= decResult;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pcHighLatch <= 8'h00;
        end else if (wrLatch) begin
            pcHighLatch <= {1'b0, pwdata[6:0]};
        end
    end

    for (genvar i = 0; i < 2; i++) begin : g_ptr
        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                ptr[i] <= PTR_RST;
            end else if (wrPtr[i]) begin
                ptr[i] <= pwdata[PTR_W-1:0];
            end else if (exec && ptrSel == 1'(i) && dec.addPtr) begin
                ptr[i] <= ptrIdx;
            end else if (exec && ptrSel == 1'(i) && modAccess) begin
                ptr[i] <= ptrMod;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            optionReg    <= OPTION_RST;
            pinDirReg[0] <= PINDIR_RST;
            pinDirReg[1] <= PINDIR_RST;
            pinDirReg[2] <= PINDIR_RST;
        end else if (exec && dec.option) begin
            optionReg <= wreg;
        end else if (exec && dec.pinDir) begin
            pinDirReg[dirIdx] <= wreg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            zeroFlag      <= 1'b0;
            timeoutFlag   <= 1'b1;
            powerdownFlag <= 1'b1;
        end else if (exec && dec.sleep) begin
            timeoutFlag   <= 1'b1;
            powerdownFlag <= 1'b0;
        end else if (exec && (dec.readMod || dec.readIdx)) begin
            zeroFlag <= (memRdata == 8'h00);
        end
    end

    // Wake pin is asynchronous; only the agreeing later stages are looked at
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wakeSync <= 3'h0;
        end else begin
            wakeSync <= {wakeSync[1:0], wakePin};
        end
    end

    a_branch_flush: assert property (@(posedge core_clk) disable iff (sys_rst)
        exec && dec.branchRel |=> state == SQ_FLUSH ##1 (state == SQ_EXEC) == $past(instrValid))
        else $error("relative branch did not take two cycles");
    a_branch_pc: assert property (@(posedge core_clk) disable iff (sys_rst)
        exec && dec.branchRel |=> pc == $past(pc) + 15'h0001 + {7'h00, $past(wreg)})
        else $error("relative branch target wrong");
    a_call_target: assert property (@(posedge core_clk) disable iff (sys_rst)
        exec && dec.callRel |=> pc == {$past(pcHighLatch[6:0]), $past(wreg)} && state == SQ_FLUSH)
        else $error("call target or flush wrong");
    a_call_push: assert property (@(posedge core_clk) disable iff (sys_rst)
        exec && dec.callRel |=> sp == SPW'($past(sp) + 1'b1) && retStack[$past(sp)] == $past(pcInc))
        else $error("call did not push return address");
    a_ret_literal: assert property (@(posedge core_clk) disable iff (sys_rst)
        exec && dec.retLit && !wrW |=> wreg == $past(litByte) && pc == $past(stackTop))
        else $error("return did not load literal and address");
    a_sleep_flags: assert property (@(posedge core_clk) disable iff (sys_rst)
        exec && dec.sleep |=> timeoutFlag && !powerdownFlag && standby)
        else $error("standby entry flags wrong");
    a_option_copy: assert property (@(posedge core_clk) disable iff (sys_rst)
        exec && dec.option && !wrW |=> optionReg == $past(wreg) && state == SQ_EXEC)
        else $error("option load failed");
    a_addptr_flags: assert property (@(posedge core_clk) disable iff (sys_rst)
        exec && dec.addPtr |=> $stable(zeroFlag) && ptr[$past(ptrSel)] == $past(ptrIdx))
        else $error("pointer add wrong or touched zero flag");
    a_extra_stall: assert property (@(posedge core_clk) disable iff (sys_rst)
        exec && extra && !pcChange |=> !instrReady ##1 instrReady)
        else $error("extra cycle for high pointer missing");
    a_skip_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
        exec && dec.decSkip |=> (state == SQ_FLUSH) == ($past(decResult) == 8'h00))
        else $error("decrement skip decision wrong");
    a_jump_target: assert property (@(posedge core_clk) disable iff (sys_rst)
        exec && dec.jumpAbs |=> pc == {$past(pcHighLatch[6:3]), $past(instr[10:0])} && state == SQ_FLUSH)
        else $error("jump target or flush wrong");
    a_flush_once: assert property (@(posedge core_clk) disable iff (sys_rst)
        state == SQ_FLUSH && instrValid |=> state == SQ_EXEC)
        else $error("flush lasted beyond one fetched word");
    a_skip_pc: assert property (@(posedge core_clk) disable iff (sys_rst)
        exec && skip |=> pc == $past(pc) + 15'h0002)
        else $error("skip did not step past the next word");
    a_pindir_copy: assert property (@(posedge core_clk) disable iff (sys_rst)
        exec && dec.pinDir |=> pinDirReg[$past(dirIdx)] == $past(wreg))
        else $error("pin direction load failed");
    a_ptr_modify: assert property (@(posedge core_clk) disable iff (sys_rst)
        exec && modAccess && !wrPtr[ptrSel] |=> ptr[$past(ptrSel)] == $past(ptrMod))
        else $error("pointer modify wrong");
    a_read_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
        exec && (dec.readMod || dec.readIdx) && !wrW |=> wreg == $past(memRdata) && zeroFlag == ($past(memRdata) == 8'h00))
        else $error("indirect read or zero flag wrong");
    a_write_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
        exec && (dec.writeMod || dec.writeIdx) |-> memReq.write ##1 $stable(zeroFlag))
        else $error("indirect write missing or touched flags");
    a_dest_file: assert property (@(posedge core_clk) disable iff (sys_rst)
        exec && dec.decSkip && destFile && !wrW |-> memReq.write ##1 $stable(wreg))
        else $error("file destination not honoured");
    a_flush_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
        state == SQ_FLUSH |-> !memReq.write ##1 $stable(pc) || state == SQ_FLUSH)
        else $error("flushed instruction had an effect");
endmodule

// *** testbench/enhanced_midrange_instruction_decoder_bench.sv ***
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
module enhanced_midrange_instruction_decoder_bench import decoder_pkg::*; ;
    logic               core_clk, sys_rst, instrValid, wakePin, instrReady, standby;
    logic               psel, penable, pwrite, pready, pslverr, rdyNext;
    logic [INSTR_W-1:0] instr;
    logic [PC_W-1:0]    pc, pcv;
    logic [DATA_W-1:0]  memRdata, w, lat, k8;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata;
    logic [PTR_W-1:0]   base, ea;
    logic [23:0]        dirs;
    logic [10:0]        k;
    logic [5:0]         k6;
    mem_req_s           memReq;
    logic [32:0]        expQ[$];
    string              nmQ[$];
    logic [23:0]        memQ[$];
    int                 num_errors = 0;
    int                 n_compared = 0;

    instr_decoder u_instr_decoder (
        .core_clk(core_clk), .sys_rst(sys_rst), .instr(instr), .instrValid(instrValid),
        .instrReady(instrReady), .pc(pc), .memReq(memReq), .memRdata(memRdata),
        .wakePin(wakePin), .standby(standby), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr)
    );
    // Data memory model: value follows the address, so every read is predictable
    assign memRdata = memReq.addr[7:0] ^ 8'h5A;

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic done(input string t);
        $display("Test %s finished, mismatches %0d", t, num_errors);
    endtask

    function automatic logic [15:0] sx(input logic [5:0] v);
        return {{10{v[5]}}, v};
    endfunction

    // Watcher: each read completion or memory write takes the oldest note
    always @(posedge core_clk) begin
        if (psel && penable && pready && !pwrite) begin
            check(nmQ.pop_front(), {pslverr, prdata}, expQ.pop_front());
        end
        if (memReq.write === 1'b1) begin
            if (memQ.size() == 0) check("memReq unexpected", 33'h1, 33'h0);
            else check("memReq", {9'h0, memReq.addr, memReq.wdata}, {9'h0, memQ.pop_front()});
        end
    end

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e, input string nm);
        expQ.push_back(e);
        nmQ.push_back(nm);
        apb(1'b0, a, 32'h0);
    endtask

    // One instruction; a low cycle follows so a flush state is never left early
    task automatic ex(input logic [13:0] wd);
        instr      <= wd;
        instrValid <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (instrReady !== 1'b1);
        instrValid <= 1'b0;
        #1 rdyNext = instrReady;
        @(posedge core_clk);
    endtask

    initial begin
        repeat (5000) @(posedge core_clk);
        num_errors++;
        stop_test();
    end

    initial begin
        sys_rst    = 1'b1;
        instr      = 14'h0000;
        instrValid = 1'b0;
        wakePin    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        void'($urandom(16352));
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        rd(REG_STATUS, 33'h6, "status");
        rd(REG_OPTION, {25'h0, OPTION_RST}, "option");
        rd(REG_PINDIR, 33'hFFFFFF, "pindir");
        rd(8'h20, 33'h100000000, "unmapped");
        done("reset");
        for (int i = 0; i < 3; i++) begin
            lat = 8'($urandom) & 8'h7F;
            k   = 11'($urandom);
            apb(1'b1, REG_PC_LATCH, {24'h0, lat});
            ex({OPC_JUMP_ABS_HI, k});
            ex(14'h0000);
            pcv = {lat[6:3], k};
            rd(REG_PC, {18'h0, pcv}, "pc jump");
        end
        w = 8'($urandom);
        apb(1'b1, REG_WREG, {24'h0, w});
        ex(OPC_BRANCH_REL_WREG);
        ex(14'h0000);
        pcv = pcv + 15'd1 + {7'h0, w};
        rd(REG_PC, {18'h0, pcv}, "pc branch");
        w   = 8'($urandom);
        lat = 8'($urandom) & 8'h7F;
        apb(1'b1, REG_WREG, {24'h0, w});
        apb(1'b1, REG_PC_LATCH, {24'h0, lat});
        ex(OPC_CALL_REL_WREG);
        ex(14'h0000);
        rd(REG_PC, {18'h0, lat[6:0], w}, "pc call");
        k8 = 8'($urandom);
        ex({OPC_RETURN_LIT_HI, k8});
        ex(14'h0000);
        pcv = pcv + 15'd1;
        rd(REG_PC, {18'h0, pcv}, "pc return");
        rd(REG_WREG, {25'h0, k8}, "w literal");
        done("control");
        dirs = 24'hFFFFFF;
        for (int s = 4; s < 8; s++) begin
            w = 8'($urandom);
            apb(1'b1, REG_WREG, {24'h0, w});
            ex(s == 4 ? OPC_OPTION : {OPC_PIN_DIR_HI, 3'(s)});
            if (s > 4) dirs[(s - 5) * 8 +: 8] = w;
            rd(s == 4 ? REG_OPTION : REG_PINDIR, s == 4 ? {25'h0, w} : {9'h0, dirs}, "cfg");
        end
        for (int n = 0; n < 2; n++) begin
            base = 16'($urandom);
            k6   = 6'($urandom);
            apb(1'b1, n ? REG_PTR1 : REG_PTR0, {16'h0, base});
            ex({OPC_ADD_PTR_HI, 1'(n), k6});
            rd(n ? REG_PTR1 : REG_PTR0, {17'h0, base + sx(k6)}, "ptr add");
        end
        rd(REG_STATUS, 33'h6, "flags after add");
        done("inherent");
        for (int n = 0; n < 2; n++) begin
            base = {n[0], 15'($urandom) & 15'h00FF};
            k6   = 6'($urandom);
            ea   = base + sx(k6);
            apb(1'b1, n ? REG_PTR1 : REG_PTR0, {16'h0, base});
            ex({OPC_IDXRD_HI, 1'(n), k6});
            check("extra cycle", {32'h0, rdyNext}, {32'h0, ~ea[15]});
            w = ea[7:0] ^ 8'h5A;
            rd(REG_WREG, {25'h0, w}, "w indexed");
            memQ.push_back({ea, w});
            ex({OPC_IDXWR_HI, 1'(n), k6});
        end
        for (int i = 0; i < 9; i++) begin
            base = (i == 8) ? 16'h8059 : 16'h0059 + 16'(i);
            ea   = base + (i[1:0] == MM_PRE_INC ? 16'h1 : i[1:0] == MM_PRE_DEC ? 16'hFFFF : 16'h0);
            apb(1'b1, i[2] ? REG_PTR1 : REG_PTR0, {16'h0, base});
            ex({OPC_IND_READ_HI, i[2], i[1:0]});
            check("extra cycle", {32'h0, rdyNext}, {32'h0, ~ea[15]});
            w = ea[7:0] ^ 8'h5A;
            rd(REG_WREG, {25'h0, w}, "w indirect");
            rd(REG_STATUS, {29'h0, 3'b011, w == 8'h00}, "zero flag");
            base = base + (i[1:0] == MM_POST_INC ? 16'h1 : i[1:0] == MM_POST_DEC ? 16'hFFFF : 16'h0);
            rd(i[2] ? REG_PTR1 : REG_PTR0, {17'h0, i[1:0] < 2 ? ea : base}, "ptr modify");
        end
        done("indirect");
        ex({OPC_JUMP_ABS_HI, 11'h123});
        ex(14'h0000);
        pcv = {lat[6:3], 11'h123} + 15'd1;
        ex({OPC_DEC_SKIP_HI, 1'b0, 7'h58});
        rd(REG_WREG, 33'h1, "dec to w");
        rd(REG_STATUS, 33'h7, "flags kept");
        memQ.push_back({16'h005B, 8'h00});
        ex({OPC_DEC_SKIP_HI, 1'b1, 7'h5B});
        // A jump as the skipped word shows whether it was really dropped
        ex({OPC_JUMP_ABS_HI, 11'h000});
        pcv = pcv + 15'd2;
        rd(REG_PC, {18'h0, pcv}, "pc skip");
        rd(REG_WREG, 33'h1, "w kept");
        done("skip");
        ex(OPC_SLEEP);
        pcv = pcv + 15'd1;
        rd(REG_STATUS, 33'hB, "standby flags");
        wakePin <= 1'b1;
        @(posedge core_clk);
        for (int j = 0; j < 20 && standby === 1'b1; j++) @(posedge core_clk);
        wakePin <= 1'b0;
        check("woken", {32'h0, standby}, 33'h0);
        rd(REG_PC, {18'h0, pcv}, "pc after standby");
        rd(REG_STATUS, 33'h3, "flags after wake");
        check("pending writes", 33'(memQ.size()), 33'h0);
        done("standby");
        stop_test();
    end
endmodule
